// ==== hdl/lcd_drv_pkg.sv ====
/*
 * Shared constants, register map and carrier types for the 40-output
 * static display driver. Assumes a single 25 MHz system clock domain.
 */
package lcd_drv_pkg;
    localparam int CH_BITS = 20;
    localparam int NUM_CH = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int FRAME_W = CH_BITS * NUM_CH;
    localparam int AXI_AW = 8;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LATCH1 = 8'h08;
    localparam logic [7:0] OFS_LATCH2 = 8'h0C;
    localparam logic [7:0] OFS_FIFO_LO = 8'h10;
    localparam logic [7:0] OFS_FIFO_HI = 8'h14;

    localparam int CTRL_DRIVE_BIT = 0;
    localparam int CTRL_CAPTURE_BIT = 1;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_PIN_LSB = 4;
    localparam int STAT_COUNT_LSB = 16;
    localparam int HI_VALID_BIT = 31;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [CH_BITS-1:0] sr;
        logic [CH_BITS-1:0] latch;
    } chan_s;

    typedef struct packed {
        logic latch_strobe;
        logic shift_strobe;
        logic alternation;
        logic channel2_mode_select;
        logic shift_dir_sel_ch1;
        logic shift_dir_sel_ch2;
        logic ch1_left;
        logic ch1_right;
        logic ch2_left;
        logic ch2_right;
    } pins_s;

    typedef struct packed {
        logic capture_en;
        logic drive_en;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = 2'h3;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_e;
endpackage

// ==== hdl/frame_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides and an occupancy count.
 * Assumes push and pop come from the same clock domain.
 */
`timescale 1ns/1ps
module frame_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop)
        begin
            cnt_d = (PW+1)'(cnt_q + 1'b1);
        end
        else if (pop && !push)
        begin
            cnt_d = (PW+1)'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign count = cnt_q;
endmodule

// ==== hdl/static_lcd_shift_latch_driver.sv ====
/*
 * Two 20-bit bidirectional shift/latch channels driving 40 display
 * outputs, strobed by an external display controller, with an AXI4-Lite
 * register slave and a 16-frame capture FIFO of latched frames.
 * Assumes all controller pins are asynchronous to aclk and much slower.
 */
`timescale 1ns/1ps
module static_lcd_shift_latch_driver #(
    parameter int FIFO_DEPTH = lcd_drv_pkg::FIFO_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [lcd_drv_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [lcd_drv_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic latch_strobe,
    input wire logic shift_strobe,
    input wire logic alternation,
    input wire logic channel2_mode_select,
    input wire logic shift_dir_sel_ch1,
    input wire logic shift_dir_sel_ch2,
    input wire logic ch1_left_serial_port_level,
    output logic ch1_left_serial_port_drive,
    output logic ch1_left_serial_port_drive_en,
    input wire logic ch1_right_serial_port_level,
    output logic ch1_right_serial_port_drive,
    output logic ch1_right_serial_port_drive_en,
    input wire logic ch2_left_serial_port_level,
    output logic ch2_left_serial_port_drive,
    output logic ch2_left_serial_port_drive_en,
    input wire logic ch2_right_serial_port_level,
    output logic ch2_right_serial_port_drive,
    output logic ch2_right_serial_port_drive_en,
    output logic [lcd_drv_pkg::FRAME_W-1:0] drive_outputs
);
    localparam int N = lcd_drv_pkg::CH_BITS;
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    lcd_drv_pkg::pins_s pin_raw, s1_q, s2_q, s3_q;
    lcd_drv_pkg::chan_s ch_q [2];
    lcd_drv_pkg::chan_s ch_d [2];
    lcd_drv_pkg::ctrl_s ctrl_q, ctrl_d;
    lcd_drv_pkg::wr_state_e wst_q, wst_d;
    lcd_drv_pkg::rd_state_e rst_q, rst_d;
    logic [lcd_drv_pkg::FRAME_W-1:0] drive_q, drive_d, fifo_out;
    logic [3:0] ser_drv_q, ser_drv_d, ser_en_q, ser_en_d;
    logic [lcd_drv_pkg::AXI_AW-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic ovf_q, ovf_d;
    logic [1:0] shift_ev, latch_ev, dir, left_in, right_in;
    logic fall_ls, rise_ls, fall_ss, rise_ss, mode, alt;
    logic fifo_in_ready, fifo_out_valid, pop, push_try, ovf_clr;
    logic [CW-1:0] fifo_count;
    logic [lcd_drv_pkg::AXI_AW-1:0] rd_addr, wr_addr;

    assign pin_raw = {latch_strobe, shift_strobe, alternation, channel2_mode_select,
        shift_dir_sel_ch1, shift_dir_sel_ch2, ch1_left_serial_port_level,
        ch1_right_serial_port_level, ch2_left_serial_port_level,
        ch2_right_serial_port_level};

    frame_fifo #(
        .WIDTH(lcd_drv_pkg::FRAME_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(push_try),
        .in_ready(fifo_in_ready),
        .in_data({ch_d[1].latch, ch_d[0].latch}),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out),
        .count(fifo_count)
    );

    // strobe edges and channel event routing
    always_comb
    begin
        fall_ls = s3_q.latch_strobe && !s2_q.latch_strobe;
        rise_ls = !s3_q.latch_strobe && s2_q.latch_strobe;
        fall_ss = s3_q.shift_strobe && !s2_q.shift_strobe;
        rise_ss = !s3_q.shift_strobe && s2_q.shift_strobe;
        mode = s2_q.channel2_mode_select;
        alt = s2_q.alternation;
        shift_ev[0] = fall_ss;
        latch_ev[0] = fall_ls;
        shift_ev[1] = mode ? rise_ls : fall_ss;
        latch_ev[1] = mode ? rise_ss : fall_ls;
        dir = {s2_q.shift_dir_sel_ch2, s2_q.shift_dir_sel_ch1};
        left_in = {s2_q.ch2_left, s2_q.ch1_left};
        right_in = {s2_q.ch2_right, s2_q.ch1_right};
    end

    // shift registers, latches, drive levels
    always_comb
    begin
        for (int c = 0; c < lcd_drv_pkg::NUM_CH; c++)
        begin
            ch_d[c] = ch_q[c];
            if (latch_ev[c])
            begin
                ch_d[c].latch = ch_q[c].sr;
            end
            if (shift_ev[c])
            begin
                // direction high: right end in, left end out
                ch_d[c].sr = dir[c] ? {ch_q[c].sr[N-2:0], right_in[c]}
                    : {left_in[c], ch_q[c].sr[N-1:1]};
            end
            ser_drv_d[2*c] = ch_d[c].sr[N-1];
            ser_drv_d[2*c+1] = ch_d[c].sr[0];
            ser_en_d[2*c] = dir[c];
            ser_en_d[2*c+1] = !dir[c];
        end
        // level = bit xor phase, ch2 phase inverted in swapped mode; with drive_en set, two outputs of one channel differ exactly when bits differ
        drive_d = '0;
        if (ctrl_q.drive_en)
        begin
            drive_d[N-1:0] = ch_d[0].latch ^ {N{alt}};
            drive_d[2*N-1:N] = ch_d[1].latch ^ {N{alt ^ mode}};
        end
    end

    // register slave and capture path
    always_comb
    begin
        rd_addr = {araddr[lcd_drv_pkg::AXI_AW-1:2], 2'h0};
        wr_addr = {awaddr_q[lcd_drv_pkg::AXI_AW-1:2], 2'h0};
        push_try = ctrl_q.capture_en && latch_ev[0];
        ovf_clr = 1'b0;
        wst_d = wst_q;
        rst_d = rst_q;
        ctrl_d = ctrl_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        bresp_d = bresp_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        pop = 1'b0;
        case (wst_q)
            lcd_drv_pkg::WR_COLLECT:
            begin
                if (awvalid && awready_q)
                begin
                    aw_got_d = 1'b1;
                    awaddr_d = awaddr;
                end
                if (wvalid && wready_q)
                begin
                    w_got_d = 1'b1;
                    wdata_d = wdata;
                    wstrb_d = wstrb;
                end
                if (aw_got_q && w_got_q)
                begin
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    wst_d = lcd_drv_pkg::WR_RESP;
                    bresp_d = lcd_drv_pkg::RESP_OKAY;
                    case (wr_addr)
                        lcd_drv_pkg::OFS_CTRL:
                        begin
                            if (wstrb_q[0])
                            begin
                                ctrl_d.drive_en = wdata_q[lcd_drv_pkg::CTRL_DRIVE_BIT];
                                ctrl_d.capture_en = wdata_q[lcd_drv_pkg::CTRL_CAPTURE_BIT];
                            end
                        end
                        lcd_drv_pkg::OFS_STATUS:
                        begin
                            ovf_clr = wstrb_q[0] && wdata_q[lcd_drv_pkg::STAT_OVF_BIT];
                        end
                        lcd_drv_pkg::OFS_LATCH1, lcd_drv_pkg::OFS_LATCH2,
                        lcd_drv_pkg::OFS_FIFO_LO, lcd_drv_pkg::OFS_FIFO_HI:
                        begin
                            bresp_d = lcd_drv_pkg::RESP_OKAY;
                        end
                        default:
                        begin
                            bresp_d = lcd_drv_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            lcd_drv_pkg::WR_RESP:
            begin
                if (bready)
                begin
                    wst_d = lcd_drv_pkg::WR_COLLECT;
                end
            end
            default:
            begin
                wst_d = lcd_drv_pkg::WR_COLLECT;
            end
        endcase
        awready_d = (wst_d == lcd_drv_pkg::WR_COLLECT) && !aw_got_d;
        wready_d = (wst_d == lcd_drv_pkg::WR_COLLECT) && !w_got_d;
        case (rst_q)
            lcd_drv_pkg::RD_IDLE:
            begin
                if (arvalid && arready_q)
                begin
                    rst_d = lcd_drv_pkg::RD_RESP;
                    rresp_d = lcd_drv_pkg::RESP_OKAY;
                    rdata_d = '0;
                    case (rd_addr)
                        lcd_drv_pkg::OFS_CTRL:
                        begin
                            rdata_d[lcd_drv_pkg::CTRL_DRIVE_BIT] = ctrl_q.drive_en;
                            rdata_d[lcd_drv_pkg::CTRL_CAPTURE_BIT] = ctrl_q.capture_en;
                        end
                        lcd_drv_pkg::OFS_STATUS:
                        begin
                            rdata_d[lcd_drv_pkg::STAT_OVF_BIT] = ovf_q;
                            rdata_d[lcd_drv_pkg::STAT_PIN_LSB +: 10] = s2_q;
                            rdata_d[lcd_drv_pkg::STAT_COUNT_LSB +: CW] = fifo_count;
                        end
                        lcd_drv_pkg::OFS_LATCH1:
                        begin
                            rdata_d[N-1:0] = ch_q[0].latch;
                        end
                        lcd_drv_pkg::OFS_LATCH2:
                        begin
                            rdata_d[N-1:0] = ch_q[1].latch;
                        end
                        lcd_drv_pkg::OFS_FIFO_LO:
                        begin
                            rdata_d = fifo_out[31:0];
                        end
                        lcd_drv_pkg::OFS_FIFO_HI:
                        begin
                            // empty fifo reads as zero rather than a stale entry
                            if (fifo_out_valid)
                            begin
                                rdata_d[lcd_drv_pkg::FRAME_W-33:0] =
                                    fifo_out[lcd_drv_pkg::FRAME_W-1:32];
                            end
                            rdata_d[lcd_drv_pkg::HI_VALID_BIT] = fifo_out_valid;
                            pop = fifo_out_valid;
                        end
                        default:
                        begin
                            rresp_d = lcd_drv_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            lcd_drv_pkg::RD_RESP:
            begin
                if (rready)
                begin
                    rst_d = lcd_drv_pkg::RD_IDLE;
                end
            end
            default:
            begin
                rst_d = lcd_drv_pkg::RD_IDLE;
            end
        endcase
        arready_d = (rst_d == lcd_drv_pkg::RD_IDLE);
        // a dropped frame sets overflow even in the cycle software clears it
        ovf_d = (ovf_q && !ovf_clr) || (push_try && !fifo_in_ready);
    end

    always_ff @(posedge aclk)
    begin
        // no reset here: idle pin levels are in place at release, so no false edge
        s1_q <= pin_raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (!aresetn)
        begin
            ch_q[0] <= '0;
            ch_q[1] <= '0;
            drive_q <= '0;
            ser_drv_q <= '0;
            ser_en_q <= '0;
            ctrl_q <= lcd_drv_pkg::CTRL_RESET;
            wst_q <= lcd_drv_pkg::WR_COLLECT;
            rst_q <= lcd_drv_pkg::RD_IDLE;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            bresp_q <= lcd_drv_pkg::RESP_OKAY;
            rresp_q <= lcd_drv_pkg::RESP_OKAY;
            rdata_q <= '0;
            ovf_q <= 1'b0;
        end
        else
        begin
            ch_q[0] <= ch_d[0];
            ch_q[1] <= ch_d[1];
            drive_q <= drive_d;
            ser_drv_q <= ser_drv_d;
            ser_en_q <= ser_en_d;
            ctrl_q <= ctrl_d;
            wst_q <= wst_d;
            rst_q <= rst_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            ovf_q <= ovf_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = (wst_q == lcd_drv_pkg::WR_RESP);
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = (rst_q == lcd_drv_pkg::RD_RESP);
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign drive_outputs = drive_q;
    assign {ch2_right_serial_port_drive, ch2_left_serial_port_drive,
        ch1_right_serial_port_drive, ch1_left_serial_port_drive} = ser_drv_q;
    assign {ch2_right_serial_port_drive_en, ch2_left_serial_port_drive_en,
        ch1_right_serial_port_drive_en, ch1_left_serial_port_drive_en} = ser_en_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_SHIFT_ADVANCE: assert property (
        fall_ss && !dir[0] |=> ch_q[0].sr == {$past(left_in[0]), $past(ch_q[0].sr[N-1:1])})
        else $error("ch1 did not shift on falling shift strobe");
    AST_LATCH_COPY: assert property (
        fall_ls |=> ch_q[0].latch == $past(ch_q[0].sr))
        else $error("ch1 latch missed falling latch strobe");
    AST_LIT_DIFFER: assert property (
        $past(ctrl_q.drive_en) |-> ((drive_outputs[0] ^ drive_outputs[1])
            == (ch_q[0].latch[0] ^ ch_q[0].latch[1])))
        else $error("lit state does not follow latch difference");
    AST_DRIVE_AT_LATCH: assert property (
        fall_ls && ctrl_q.drive_en |=> drive_outputs[N-1:0]
            == ($past(ch_q[0].sr) ^ {N{$past(alt)}}))
        else $error("drive did not take new data at latch");
    AST_WIDTH_DIR_RIGHT: assert property (
        !mode && fall_ss && dir[1] |=>
            ch_q[1].sr == {$past(ch_q[1].sr[N-2:0]), $past(right_in[1])})
        else $error("ch2 right-fed shift wrong");
    AST_DIR_ENDS: assert property (
        $past(aresetn) |-> ch1_left_serial_port_drive_en == $past(dir[0])
            && ch1_right_serial_port_drive_en == !$past(dir[0]))
        else $error("serial end roles do not follow direction select");
    AST_CH2_SWAP: assert property (
        mode && rise_ss |=> ch_q[1].latch == $past(ch_q[1].sr))
        else $error("ch2 did not latch on rising shift strobe in swapped mode");
    AST_CH2_ALT_INV: assert property (
        $past(mode && ctrl_q.drive_en) |->
            drive_outputs[2*N-1:N] == (ch_q[1].latch ^ {N{!$past(alt)}}))
        else $error("ch2 phase not inverted in swapped mode");
    AST_SHARED_STROBES: assert property (
        !mode && fall_ls |=> ch_q[1].latch == $past(ch_q[1].sr))
        else $error("ch2 did not latch with ch1 in normal mode");
    AST_LATCH_HOLD: assert property (
        !latch_ev[0] |=> $stable(ch_q[0].latch))
        else $error("ch1 latch changed without latch event");
endmodule

// ==== test/ctrl_model.sv ====
/*
 * Display controller stand-in: serial bits, shift and latch strobes, alternation.
 * Assumes aclk at 25 MHz; one shift takes 8 aclk, a 320 ns link period.
 */
`timescale 1ns/1ps
module ctrl_model (
    input wire logic aclk,
    output logic latch_strobe,
    output logic shift_strobe,
    output logic alternation,
    output logic d1,
    output logic d2
);
    initial
    begin
        latch_strobe = 1'b0;
        shift_strobe = 1'b1;
        alternation = 1'b0;
        d1 = 1'b0;
        d2 = 1'b1;
    end
    // data held 2 aclk either side of the falling shift edge
    task automatic send(input logic [39:0] f, input int n, input bit lat);
        for (int i = 0; i < n; i++)
        begin
            @(posedge aclk);
            d1 <= f[i];
            d2 <= f[20+i];
            repeat (2) @(posedge aclk);
            shift_strobe <= 1'b0;
            repeat (2) @(posedge aclk);
            d1 <= ~f[i];
            d2 <= ~f[20+i];
            repeat (2) @(posedge aclk);
            shift_strobe <= 1'b1;
            if (i % 5 == 4 && i < 19) alternation <= ~alternation;
            @(posedge aclk);
        end
        if (lat)
        begin
            @(posedge aclk);
            latch_strobe <= 1'b1;
            repeat (4) @(posedge aclk);
            latch_strobe <= 1'b0;
            alternation <= ~alternation;
        end
        repeat (8) @(posedge aclk);
    endtask
endmodule

// ==== test/static_lcd_shift_latch_driver_tb.sv ====
/*
 * Bench: AXI4-Lite register tasks plus the controller model on the pins.
 * Assumes pull-ups on serial pins that nobody drives.
 */
`timescale 1ns/1ps
module static_lcd_shift_latch_driver_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata, rd;
    logic dir1 = 1'b0, dir2 = 1'b0, mode = 1'b0;
    logic ls, ss, alt, d1, d2, l1o, l1e, r1o, r1e, l2o, l2e, r2o, r2e;
    logic [39:0] dout, f, e;
    int errors = 0, n_checks = 0, cyc = 0;
    wire l1 = l1e ? l1o : (dir1 ? 1'b1 : d1);
    wire r1 = r1e ? r1o : (dir1 ? d1 : 1'b1);
    wire l2 = l2e ? l2o : (dir2 ? 1'b1 : d2);
    wire r2 = r2e ? r2o : (dir2 ? d2 : 1'b1);

    always #20 aclk = ~aclk;

    ctrl_model ctrl_model_inst (.aclk(aclk), .latch_strobe(ls), .shift_strobe(ss),
        .alternation(alt), .d1(d1), .d2(d2));

    static_lcd_shift_latch_driver static_lcd_shift_latch_driver_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .latch_strobe(ls), .shift_strobe(ss),
        .alternation(alt), .channel2_mode_select(mode), .shift_dir_sel_ch1(dir1),
        .shift_dir_sel_ch2(dir2), .ch1_left_serial_port_level(l1),
        .ch1_left_serial_port_drive(l1o), .ch1_left_serial_port_drive_en(l1e),
        .ch1_right_serial_port_level(r1), .ch1_right_serial_port_drive(r1o),
        .ch1_right_serial_port_drive_en(r1e), .ch2_left_serial_port_level(l2),
        .ch2_left_serial_port_drive(l2o), .ch2_left_serial_port_drive_en(l2e),
        .ch2_right_serial_port_level(r2), .ch2_right_serial_port_drive(r2o),
        .ch2_right_serial_port_drive_en(r2e), .drive_outputs(dout));

    task end_sim;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input logic [39:0] g, input logic [39:0] x);
        n_checks++;
        if (g !== x)
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
        if (g !== x)
            errors++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(40'(bresp), 40'(x));
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        rd_reg(a);
        chk(40'(rd), 40'(x));
    endtask

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            errors++;
            end_sim;
        end
    end

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rc(8'h00, 32'h0000_0003);
        wr(8'h18, 32'h0000_0000, lcd_drv_pkg::RESP_SLVERR);
        rc(8'h18, 32'h0000_0000);
        chk(40'(rr), 40'(lcd_drv_pkg::RESP_SLVERR));
        $display("test regs done");
        wr(8'h00, 32'h0000_0001, 2'h0);
        f = 40'hA5_3C96_5E0E;
        ctrl_model_inst.send(f, 20, 1'b1);
        chk(dout, f ^ {40{alt}});
        for (int i = 1; i < 40; i++) chk(40'(dout[i] ^ dout[0]), 40'(f[i]));
        chk(40'({r1e, r1o, r2e, r2o}), {36'h0_0000_0000, 1'b1, f[0], 1'b1, f[20]});
        rc(8'h08, 32'(f[19:0]));
        rc(8'h0C, 32'(f[39:20]));
        ctrl_model_inst.send(~f, 7, 1'b0);
        chk(dout, f ^ {40{alt}});
        $display("test frame done");
        dir1 <= 1'b1;
        dir2 <= 1'b1;
        ctrl_model_inst.send(f, 20, 1'b1);
        for (int i = 0; i < 40; i++) e[i] = f[(i < 20) ? 19 - i : 59 - i];
        chk(dout, e ^ {40{alt}});
        chk(40'({l1e, l1o, l2e, l2o}), {36'h0_0000_0000, 1'b1, e[19], 1'b1, e[39]});
        $display("test direction done");
        wr(8'h00, 32'h0000_0003, 2'h0);
        repeat (17) ctrl_model_inst.send(f, 0, 1'b1);
        rd_reg(8'h04);
        chk(40'(rd & 32'h001F_0001), 40'h00_0010_0001);
        repeat (16)
        begin
            rc(8'h10, e[31:0]);
            rc(8'h14, {1'b1, 23'h00_0000, e[39:32]});
        end
        rc(8'h14, 32'h0000_0000);
        wr(8'h04, 32'h0000_0001, 2'h0);
        rd_reg(8'h04);
        chk(40'(rd & 32'h001F_0001), 40'h00_0000_0000);
        $display("test buffer done");
        mode <= 1'b1;
        repeat (8) @(posedge aclk);
        chk(dout, {e[39:20] ^ {20{~alt}}, e[19:0] ^ {20{alt}}});
        ctrl_model_inst.send(f, 1, 1'b1);
        ctrl_model_inst.send(f, 1, 1'b0);
        chk(40'(dout[39:20]), 40'({e[38:20], ~f[20]} ^ {20{~alt}}));
        $display("test mode done");
        end_sim;
    end
endmodule
